// >>> design/lcd_host.sv
// Purpose: host end, runs serial register transfers from an axi4-lite slave
// Assumes: one transfer at a time, software polls or takes the interrupt
// Notes: refuses out-of-range gate supply codes and config before ready
`timescale 1ns/1ps
`default_nettype none
module lcd_host
  import lcd_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [7:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [7:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  // interrupt
  output logic irq,
  // link
  lcd_link_if.host link
);
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} lcd_hst_phase_t;
  typedef struct packed {
    lcd_hst_phase_t ph;
    logic aw_got, w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid, rvalid;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [15:0] shift;
    logic [15:0] frame;
    logic [7:0] rd;
    logic [4:0] bits;
    logic [2:0] div;
    logic sck, cs_n;
    logic ready_seen;
    logic [1:0] ist, ien;
    logic [2:0] dim;
    logic irq;
  } lcd_hst_state_t;
  lcd_hst_state_t s_r, s_nxt;

  // next state
  always_comb begin
    logic go, refuse;
    logic [15:0] cmd;
    s_nxt = s_r;
    go = 1'b0;
    refuse = 1'b0;
    cmd = '0;
    if (s_awvalid && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_awaddr;
    end
    if (s_wvalid && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_wdata;
    end
    if (s_r.bvalid && s_bready) s_nxt.bvalid = 1'b0;
    if (s_r.rvalid && s_rready) s_nxt.rvalid = 1'b0;
    // write decode once both halves are held
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid && s_r.ph == ST_IDLE) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = 2'b00;
      case (s_r.awaddr)
        REG_CMD: begin
          cmd = s_r.wdata[15:0];
          // config before ready, or a forbidden supply code, is refused
          if (cmd[15] && cmd[14:8] != 7'h00 && !s_r.ready_seen) refuse = 1'b1; // [RL7]
          if (cmd[15] && cmd[14:8] == ADDR_GATE_SUPPLY[6:0]
              && (cmd[7:0] < GATE_SUPPLY_MIN || cmd[7:0] > GATE_SUPPLY_MAX)) refuse = 1'b1; // [RL11]
          if (cmd[15] && cmd[14:8] == 7'h00) cmd[7:0] = cmd[7:0] & FUNC_CTRL_WMASK; // [RL10]
          if (refuse) s_nxt.bresp = 2'b10;
          else go = 1'b1;
        end
        REG_IRQ_CLR: s_nxt.ist = s_r.ist & ~s_r.wdata[1:0];
        REG_IRQ_EN: s_nxt.ien = s_r.wdata[1:0];
        REG_DIM: s_nxt.dim = s_r.wdata[2:0]; // [RL18]
        default: s_nxt.bresp = 2'b10;
      endcase
    end
    if (s_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      case (s_araddr)
        REG_RDATA: s_nxt.rdata = {24'h0, s_r.rd};
        REG_STATUS: s_nxt.rdata = {30'h0, s_r.ready_seen, s_r.ph != ST_IDLE};
        REG_IRQ_STAT: s_nxt.rdata = {30'h0, s_r.ist};
        REG_IRQ_EN: s_nxt.rdata = {30'h0, s_r.ien};
        REG_DIM: s_nxt.rdata = {29'h0, s_r.dim};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // serial engine, sck = clock / (2*SCK_DIV)
    case (s_r.ph)
      ST_IDLE: begin
        if (go) begin
          s_nxt.ph = ST_SHIFT;
          s_nxt.shift = cmd;
          s_nxt.frame = cmd; // kept for the ready check at the end
          s_nxt.cs_n = 1'b0;
          s_nxt.bits = 5'd0;
          s_nxt.div = 3'd0;
        end
      end
      ST_SHIFT: begin
        s_nxt.div = s_r.div + 3'd1;
        if (s_r.div == 3'(SCK_DIV - 1)) begin
          s_nxt.div = 3'd0;
          s_nxt.sck = !s_r.sck;
          if (!s_r.sck) begin
            s_nxt.rd = {s_r.rd[6:0], link.miso};
          end else begin
            s_nxt.shift = {s_r.shift[14:0], 1'b0};
            s_nxt.bits = s_r.bits + 5'd1;
            if (s_r.bits == 5'(FRAME_BITS - 1)) s_nxt.ph = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        s_nxt.cs_n = 1'b1;
        s_nxt.ph = ST_IDLE;
        s_nxt.ist[IRQ_DONE] = 1'b1;
        // read of function control that shows ready unlocks config
        if (s_r.frame == 16'h0000 && s_r.rd[BIT_IF_READY]) s_nxt.ready_seen = 1'b1; // [RL6] [RL7]
      end
      default: s_nxt.ph = ST_IDLE;
    endcase
    if (refuse) s_nxt.ist[IRQ_RANGE] = 1'b1; // set wins over clear
    s_nxt.irq = |(s_nxt.ist & s_nxt.ien);
  end

  // one register for all state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ph <= ST_IDLE;
      s_r.cs_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_wready = !s_r.w_got && !s_r.bvalid;
  assign s_bvalid = s_r.bvalid;
  assign s_bresp = s_r.bresp;
  assign s_arready = !s_r.rvalid;
  assign s_rvalid = s_r.rvalid;
  assign s_rdata = s_r.rdata;
  assign s_rresp = 2'b00;
  assign irq = s_r.irq;
  assign link.sck = s_r.sck;
  assign link.cs_n = s_r.cs_n;
  assign link.mosi = s_r.shift[15];
  assign link.dim_input = s_r.dim;
endmodule : lcd_host
`default_nettype wire

// >>> design/lcd_pkg.sv
// Purpose: shared constants for the led channel dimming control pair
// Assumes: 8-bit register map, 16-bit serial frames, 40 MHz clock
// Notes: host register offsets are byte addresses on the axi4-lite slave
package lcd_pkg;
  localparam int unsigned NCH = 3;
  localparam logic [7:0] ADDR_FUNC_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GATE_SUPPLY = 8'h01;
  localparam logic [7:0] ADDR_DIE_TEMP = 8'h26;
  localparam int unsigned BIT_IF_READY = 7;
  localparam int unsigned BIT_ERR_CLR = 6;
  localparam int unsigned BIT_DIM_EN_LO = 1;
  localparam logic [7:0] FUNC_CTRL_RESET = 8'h00;
  localparam logic [7:0] FUNC_CTRL_WMASK = 8'hce; // bits 5:4 and 0 reserved
  localparam logic [7:0] GATE_SUPPLY_MIN = 8'h5d;
  localparam logic [7:0] GATE_SUPPLY_MAX = 8'ha6;
  localparam logic [7:0] GATE_SUPPLY_RESET = 8'h5d;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  // gate toggle half period and bootstrap timing, in cycles
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TOGGLE_HALF_NS = 1000;
  localparam int unsigned TOGGLE_HALF_CYC = (TOGGLE_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned MEAS_US = 100;
  localparam int unsigned MEAS_CYC = MEAS_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RECHARGE_US = 50;
  localparam int unsigned RECHARGE_CYC = RECHARGE_US * (CLK_HZ / 1_000_000);
  // serial command: bit 15 = write, 14:8 address, 7:0 data
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned SCK_DIV = 4;
  // interrupt status bits of the controller
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_RANGE = 1;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_RDATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_IRQ_EN = 8'h14;
  localparam logic [7:0] REG_DIM = 8'h18;
endpackage : lcd_pkg

// >>> design/lcd_link_if.sv
// Purpose: serial register link and dimming pins between host and device
// Assumes: host drives the serial clock, both ends share one system clock
// Notes: sck is sampled as a pin by the device
`timescale 1ns/1ps
`default_nettype none
interface lcd_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic [2:0] dim_input;
  modport device (input sck, input cs_n, input mosi, input dim_input, output miso);
  modport host (output sck, output cs_n, output mosi, output dim_input, input miso);
endinterface : lcd_link_if
`default_nettype wire

// >>> design/lcd_device.sv
// Purpose: device end, register bank, dimming gating and bootstrap control
// Assumes: pins are asynchronous, serial mode 0, msb first
// Notes: analog loops are modelled as plain status inputs
//
// Summary of operation
// [RL1] one dimming input drives one channel
// [RL2] input high starts gate toggling at once
// [RL3] input low stops turning gate on
// [RL4] disabled input keeps channel off always
// [RL5] function control enables at bits 3:1
// [RL6] bit 7 reads interface ready once set
// [RL7] host configures only after ready seen
// [RL8] error clear bit clears errors, self-clears
// [RL9] clear request pends until an error
// [RL10] host writes reserved bits as zero
// [RL11] gate supply code, allowed 0x5d..0xa6
// [RL12] host reads gate supply back after write
// [RL13] temperature register reads signed degrees
// [RL14] host uses overtemp flag when out of range
// [RL15] bootstrap recharge when not switching
// [RL16] charge maintain only when idle and healthy
// [RL17] supply fault cleared by clear or off mode
// [RL18] host raises dimming after configuration
// [RL19] dimming inputs synchronised before use
`timescale 1ns/1ps
`default_nettype none
module lcd_device
  import lcd_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic rst_n,
  // link
  lcd_link_if.device link,
  // device side status and control
  input wire logic enable_in,
  input wire logic [7:0] die_temp_in,
  input wire logic gate_supply_err_evt,
  input wire logic overtemp_evt,
  input wire logic [2:0] current_reached_cmp,
  input wire logic [2:0] bootstrap_uv,
  input wire logic [2:0] low_headroom,
  output logic [2:0] gate_drive_out,
  output logic [2:0] bootstrap_recharge,
  output logic [2:0] charge_maintain,
  output logic gate_supply_fault,
  output logic overtemp_flag
);
  // all state in one word: pin stages, serial slave, registers, channels
  typedef struct packed {
    logic [2:0] sck_s, cs_s, mosi_s;
    logic [2:0][2:0] dim_s;
    logic [2:0] dim_q;
    logic [3:0] bitcnt;
    logic [15:0] shift;
    logic miso;
    logic [7:0] func;
    logic [7:0] gsup;
    logic [7:0] temp;
    logic gfault, otemp;
    logic [2:0][15:0] tcnt;
    logic [2:0] gate;
    logic [2:0][15:0] lowcnt;
    logic [2:0][15:0] rcnt;
    logic [2:0] rch, cm;
  } lcd_dev_state_t;
  lcd_dev_state_t s_r, s_nxt;

  // read mux for the serial link
  // unmapped addresses read as zero, with no error back to the host
  function automatic logic [7:0] rd_reg(input lcd_dev_state_t s, input logic [6:0] a);
    case ({1'b0, a})
      ADDR_FUNC_CTRL: rd_reg = s.func;
      ADDR_GATE_SUPPLY: rd_reg = s.gsup;
      ADDR_DIE_TEMP: rd_reg = s.temp; // [RL13]
      default: rd_reg = 8'h00;
    endcase
  endfunction : rd_reg

  // next state: serial slave, register effects, channel logic
  always_comb begin
    logic sck_rise, sck_fall, cs_act, err_any;
    logic [2:0] dim_live;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    cs_act = 1'b0;
    err_any = 1'b0;
    dim_live = '0;
    s_nxt = s_r;
    // three-stage pin sampling, stage 1 read only by stage 2
    s_nxt.sck_s = {s_r.sck_s[1:0], link.sck};
    s_nxt.cs_s = {s_r.cs_s[1:0], link.cs_n};
    s_nxt.mosi_s = {s_r.mosi_s[1:0], link.mosi};
    for (int i = 0; i < NCH; i++) begin
      s_nxt.dim_s[i] = {s_r.dim_s[i][1:0], link.dim_input[i]}; // [RL19]
      if (s_r.dim_s[i][1] == s_r.dim_s[i][2]) begin
        s_nxt.dim_q[i] = s_r.dim_s[i][2];
      end
    end
    // an edge counts only once stages two and three disagree
    sck_rise = (s_r.sck_s[2:1] == 2'b01);
    sck_fall = (s_r.sck_s[2:1] == 2'b10);
    cs_act = !s_r.cs_s[2] && !s_r.cs_s[1];
    // frame: write flag, seven address bits, eight data bits, msb first;
    // a read answers in the same frame, so the data is loaded after the
    // eighth rising edge and leaves on the following falling edges
    if (!cs_act) begin
      s_nxt.bitcnt = 4'd0;
    end else if (sck_rise) begin
      s_nxt.shift = {s_r.shift[14:0], s_r.mosi_s[2]};
      s_nxt.bitcnt = s_r.bitcnt + 4'd1;
      if (s_r.bitcnt == 4'd7 && !s_r.shift[6]) begin
        // address lsb is still in the pin stage, not yet in the shifter
        s_nxt.shift = {rd_reg(s_r, {s_r.shift[5:0], s_r.mosi_s[2]}), 7'h00, s_r.mosi_s[2]};
      end
      if (s_r.bitcnt == 4'd15 && s_r.shift[14]) begin
        case ({1'b0, s_r.shift[13:7]})
          ADDR_FUNC_CTRL: begin
            // reserved bits dropped; ready bit sticks once set
            s_nxt.func = ({s_r.shift[6:0], s_r.mosi_s[2]} & FUNC_CTRL_WMASK)
                         | (s_r.func & 8'h80); // [RL5] [RL6]
          end
          ADDR_GATE_SUPPLY: s_nxt.gsup = {s_r.shift[6:0], s_r.mosi_s[2]}; // [RL11]
          default: ;
        endcase
      end
    end
    // miso moves on falling edges so the host finds it settled on its rise
    if (cs_act && sck_fall) begin
      s_nxt.miso = (s_r.bitcnt >= 4'd8) ? s_r.shift[15] : 1'b0;
    end
    // errors are sticky; a pending clear wipes them and is consumed
    // an error in the same cycle as a pending clear is swallowed at once
    if (gate_supply_err_evt) s_nxt.gfault = 1'b1;
    if (overtemp_evt) s_nxt.otemp = 1'b1;
    err_any = s_nxt.gfault || s_nxt.otemp;
    if (s_r.func[BIT_ERR_CLR] && err_any) begin
      s_nxt.gfault = 1'b0; // [RL8] [RL9] [RL17]
      s_nxt.otemp = 1'b0;
      s_nxt.func[BIT_ERR_CLR] = 1'b0;
    end
    // off mode also drops the ready bit; the host has to set it again
    if (!enable_in) begin
      s_nxt.gfault = 1'b0; // [RL17]
      s_nxt.func = FUNC_CTRL_RESET;
    end
    s_nxt.temp = die_temp_in;
    // channels: enable, synchronised input, and no fault
    // any fault or a disabled input parks the gate low and rearms the counter
    for (int i = 0; i < NCH; i++) begin
      dim_live[i] = s_r.dim_q[i] && s_r.func[BIT_DIM_EN_LO + i] && enable_in
                    && !s_r.gfault && !s_r.otemp; // [RL1] [RL4]
      // the first edge of a burst switches at once, later ones every TOGGLE_HALF_CYC - 1 cycles
      if (!dim_live[i]) begin
        s_nxt.gate[i] = 1'b0; // [RL3]
        s_nxt.tcnt[i] = '0;
      end else if (s_r.tcnt[i] == 16'(TOGGLE_HALF_CYC - 1) || !s_r.gate[i] && s_r.tcnt[i] == 0) begin
        s_nxt.gate[i] = !s_r.gate[i]; // [RL2]
        s_nxt.tcnt[i] = 16'd1;
      end else begin
        s_nxt.tcnt[i] = s_r.tcnt[i] + 16'd1;
      end
      // low time count saturates at the measurement interval
      // saturating keeps a long low time from wrapping back to a short one
      if (s_r.dim_q[i]) s_nxt.lowcnt[i] = '0;
      else if (s_r.lowcnt[i] < 16'(MEAS_CYC)) s_nxt.lowcnt[i] = s_r.lowcnt[i] + 16'd1;
      // one-cycle recharge pulse each interval while switching does not refresh
      s_nxt.rch[i] = 1'b0;
      if ((s_r.lowcnt[i] >= 16'(MEAS_CYC) && !s_r.dim_q[i])
          || (s_r.dim_q[i] && !current_reached_cmp[i])) begin
        if (s_r.rcnt[i] >= 16'(RECHARGE_CYC - 1)) begin
          s_nxt.rcnt[i] = '0;
          s_nxt.rch[i] = 1'b1; // [RL15]
        end else begin
          s_nxt.rcnt[i] = s_r.rcnt[i] + 16'd1;
        end
      end else begin
        s_nxt.rcnt[i] = '0;
      end
      // registered, so maintaining follows its inputs one cycle late
      s_nxt.cm[i] = enable_in && !s_r.gfault && !s_r.otemp && !s_r.dim_q[i]
                    && !bootstrap_uv[i] && !low_headroom[i]; // [RL16]
    end
  end

  // one register for all state
  // chip select stages reset high to match an idle link, so no false frame start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.sck_s <= '0;
      s_r.cs_s <= 3'b111;
      s_r.gsup <= GATE_SUPPLY_RESET;
      s_r.func <= FUNC_CTRL_RESET;
      s_r.temp <= TEMP_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs come straight from the state register
  assign link.miso = s_r.miso;
  assign gate_drive_out = s_r.gate;
  assign bootstrap_recharge = s_r.rch;
  assign charge_maintain = s_r.cm;
  assign gate_supply_fault = s_r.gfault;
  assign overtemp_flag = s_r.otemp;
endmodule : lcd_device
`default_nettype wire

// >>> bench/lcd_monitor.sv
// Purpose: link and channel pin checks beside the host/device pair
// Assumes: one clock, device outputs registered
// Notes: pin sync adds two to five cycles of lag
`timescale 1ns/1ps
`default_nettype none
module lcd_monitor (
  // system
  input wire logic clock,
  input wire logic rst_n,
  // link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [2:0] dim_input,
  // device pins
  input wire logic [2:0] gate_drive_out,
  input wire logic [2:0] bootstrap_recharge,
  input wire logic [2:0] charge_maintain,
  input wire logic [2:0] bootstrap_uv,
  input wire logic [2:0] low_headroom
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // mode 0 keeps the serial clock low between frames
  sck_idle_a: assert property (cs_n && $past(cs_n) |-> !sck) else $error("sck outside frame");
  for (genvar i = 0; i < 3; i++) begin : g_ch
    // six cycles covers the synchroniser and output register
    sequence s_low;
      !dim_input[i] [*6];
    endsequence
    sequence s_high;
      dim_input[i] [*6];
    endsequence
    dim_off_a: assert property (s_low |-> !gate_drive_out[i])
      else $error("gate on with pin low");
    dim_own_a: assert property ($rose(gate_drive_out[i]) |->
      $past(dim_input[i], 2) || $past(dim_input[i], 3) || $past(dim_input[i], 4)
      || $past(dim_input[i], 5))
      else $error("gate rose without own pin");
    maint_dim_a: assert property (s_high |-> !charge_maintain[i])
      else $error("maintain with pin high");
    maint_uv_a: assert property (bootstrap_uv[i] [*4] |-> !charge_maintain[i])
      else $error("maintain under bootstrap uv");
    maint_hr_a: assert property (low_headroom[i] [*4] |-> !charge_maintain[i])
      else $error("maintain with low headroom");
    rchg_pulse_a: assert property (bootstrap_recharge[i] |=> !bootstrap_recharge[i])
      else $error("recharge pulse too long");
  end
endmodule : lcd_monitor
`default_nettype wire

// >>> bench/tb_led_channel_dimming_control.sv
// Purpose: end-to-end bench, axi4-lite master driving host and device
// Assumes: device status pins driven here
// Notes: driver queues expectations, a watcher compares on handshakes
`timescale 1ns/1ps
`default_nettype none
module tb_led_channel_dimming_control;
  import lcd_pkg::*;
  localparam logic [32:0] IGN = 33'h1_0000_0000;
  logic clock, rst_n, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, irq, enable_in, gs_evt, fault, otf, ot_evt;
  logic [7:0] s_awaddr, s_araddr, die_temp;
  logic [31:0] s_wdata, s_rdata, v;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic [2:0] crc, uv, hr, gate, rchg, maint, got;
  logic [7:0] codes [5];
  logic [7:0] good;
  logic [1:0] bq [$];
  logic [32:0] rq [$];
  int err_count, compares;
  lcd_link_if link ();
  lcd_host u_lcd_host (.clock(clock), .rst_n(rst_n), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_awaddr(s_awaddr), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_bresp(s_bresp), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .irq(irq), .link(link.host));
  lcd_device u_lcd_device (.clock(clock), .rst_n(rst_n), .link(link.device),
    .enable_in(enable_in), .die_temp_in(die_temp), .gate_supply_err_evt(gs_evt),
    .overtemp_evt(ot_evt), .current_reached_cmp(crc), .bootstrap_uv(uv), .low_headroom(hr),
    .gate_drive_out(gate), .bootstrap_recharge(rchg), .charge_maintain(maint),
    .gate_supply_fault(fault), .overtemp_flag(otf));
  lcd_monitor u_lcd_monitor (.clock(clock), .rst_n(rst_n), .sck(link.sck), .cs_n(link.cs_n),
    .dim_input(link.dim_input), .gate_drive_out(gate), .bootstrap_recharge(rchg),
    .charge_maintain(maint), .bootstrap_uv(uv), .low_headroom(hr));
  // clock, 25 ns period
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic wrap_up();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
    chk({30'h0, e}, {30'h0, g});
  endtask : cmp_resp
  task automatic cmp_data(input logic [31:0] e, input logic [31:0] g);
    chk(e, g);
  endtask : cmp_data
  task automatic cmp_pin(input logic [2:0] e, input logic [2:0] g);
    chk({29'h0, e}, {29'h0, g});
  endtask : cmp_pin
  task automatic tmo();
    err_count++;
    $display("timeout at %0t", $time);
    wrap_up();
  endtask : tmo
  // watcher: each completed response takes the oldest note
  always @(negedge clock) begin
    if (s_bvalid && s_bready && bq.size() > 0) cmp_resp(bq.pop_front(), s_bresp);
    if (s_rvalid && s_rready && rq.size() > 0) begin
      if (!rq[0][32]) cmp_data(rq[0][31:0], s_rdata);
      cmp_resp(2'b00, s_rresp);
      void'(rq.pop_front());
    end
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask : waitc
  // sampling half a cycle early is race free: inputs move only after rising edges
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w, b;
    bq.push_back(er);
    @(posedge clock);
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_awaddr <= a;
    s_wdata <= d;
    s_bready <= 1'b1;
    n = 0;
    b = 1'b0;
    while (!b) begin
      @(negedge clock);
      aw = s_awvalid && s_awready;
      w = s_wvalid && s_wready;
      b = s_bvalid && s_bready;
      @(posedge clock);
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
      if (b) s_bready <= 1'b0;
      n++;
      if (n > 300) tmo();
    end
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [32:0] e, output logic [31:0] d);
    int n;
    logic ar, r;
    rq.push_back(e);
    @(posedge clock);
    s_arvalid <= 1'b1;
    s_araddr <= a;
    s_rready <= 1'b1;
    n = 0;
    r = 1'b0;
    while (!r) begin
      @(negedge clock);
      ar = s_arvalid && s_arready;
      r = s_rvalid && s_rready;
      if (r) d = s_rdata;
      @(posedge clock);
      if (ar) s_arvalid <= 1'b0;
      if (r) s_rready <= 1'b0;
      n++;
      if (n > 300) tmo();
    end
  endtask : axr
  // one device access through the command register, polled until idle
  task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er, input logic [7:0] e);
    logic [31:0] s;
    int n;
    axw(REG_CMD, {16'h0000, w, a[6:0], d}, er);
    s = 32'h0000_0001;
    n = 0;
    while (er == 2'b00 && s[0]) begin
      axr(REG_STATUS, IGN, s);
      n++;
      if (n > 200) tmo();
    end
    if (!w && er == 2'b00) axr(REG_RDATA, {25'h000_0000, e}, s);
  endtask : dev
  task automatic rises(input int cyc, output logic [2:0] seen);
    logic [2:0] p;
    seen = 3'b000;
    p = gate;
    repeat (cyc) begin
      @(negedge clock);
      seen = seen | (gate & ~p);
      p = gate;
    end
  endtask : rises
  task automatic err_pulse();
    @(posedge clock);
    gs_evt <= 1'b1;
    @(posedge clock);
    gs_evt <= 1'b0;
    waitc(3);
    cmp_pin(3'b001, {2'b00, fault});
  endtask : err_pulse
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, gs_evt, ot_evt} = 7'h00;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = {16'h0000, 32'h0000_0000, 4'hf};
    {enable_in, crc, uv, hr, die_temp} = {1'b1, 9'h000, 8'h00};
    err_count = 0;
    compares = 0;
    rst_n = 1'b0;
    void'($urandom(83));
    waitc(20);
    rst_n <= 1'b1;
    axr(REG_STATUS, 33'h0_0000_0000, v);
    axr(8'h1c, IGN, v);
    axw(REG_IRQ_EN, 32'h0000_0002, 2'b00);
    dev(1'b1, ADDR_GATE_SUPPLY, 8'h80, 2'b10, 8'h00);
    waitc(3);
    cmp_pin(3'b001, {2'b00, irq});
    axr(REG_IRQ_STAT, 33'h0_0000_0002, v);
    axw(REG_IRQ_CLR, 32'h0000_0002, 2'b00);
    waitc(3);
    cmp_pin(3'b000, {2'b00, irq});
    $display("test refusal done");
    dev(1'b1, ADDR_FUNC_CTRL, 8'h80, 2'b00, 8'h00);
    dev(1'b0, ADDR_FUNC_CTRL, 8'h00, 2'b00, 8'h80);
    axr(REG_STATUS, 33'h0_0000_0002, v);
    dev(1'b0, ADDR_GATE_SUPPLY, 8'h00, 2'b00, GATE_SUPPLY_RESET);
    codes = '{8'h5c, 8'h5d, 8'ha6, 8'ha7, 8'h5d + 8'($urandom_range(73))};
    good = GATE_SUPPLY_RESET;
    foreach (codes[i]) begin
      if (codes[i] >= GATE_SUPPLY_MIN && codes[i] <= GATE_SUPPLY_MAX) good = codes[i];
      dev(1'b1, ADDR_GATE_SUPPLY, codes[i], good == codes[i] ? 2'b00 : 2'b10, 8'h00);
      dev(1'b0, ADDR_GATE_SUPPLY, 8'h00, 2'b00, good);
    end
    $display("test ready and supply done");
    codes = '{8'hd8, 8'haf, 8'hff, 8'h00, 8'($urandom())};
    foreach (codes[i]) begin
      die_temp <= codes[i];
      dev(1'b0, ADDR_DIE_TEMP, 8'h00, 2'b00, codes[i]);
    end
    dev(1'b1, ADDR_FUNC_CTRL, 8'h3f, 2'b00, 8'h00);
    dev(1'b0, ADDR_FUNC_CTRL, 8'h00, 2'b00, 8'h8e);
    axw(REG_DIM, 32'h0000_0007, 2'b00);
    rises(200, got);
    cmp_pin(3'b111, got);
    dev(1'b1, ADDR_FUNC_CTRL, 8'h8a, 2'b00, 8'h00);
    rises(200, got);
    cmp_pin(3'b101, got);
    axw(REG_DIM, 32'h0000_0000, 2'b00);
    waitc(10);
    rises(200, got);
    cmp_pin(3'b000, got);
    $display("test dimming done");
    err_pulse();
    dev(1'b1, ADDR_FUNC_CTRL, 8'hca, 2'b00, 8'h00);
    waitc(10);
    cmp_pin(3'b000, {2'b00, fault});
    dev(1'b0, ADDR_FUNC_CTRL, 8'h00, 2'b00, 8'h8a);
    dev(1'b1, ADDR_FUNC_CTRL, 8'hca, 2'b00, 8'h00);
    dev(1'b0, ADDR_FUNC_CTRL, 8'h00, 2'b00, 8'hca);
    gs_evt <= 1'b1;
    @(posedge clock);
    gs_evt <= 1'b0;
    waitc(10);
    cmp_pin(3'b000, {2'b00, fault});
    dev(1'b0, ADDR_FUNC_CTRL, 8'h00, 2'b00, 8'h8a);
    // out-of-range reading, then the overtemperature flag decides
    die_temp <= 8'hc0;
    dev(1'b0, ADDR_DIE_TEMP, 8'h00, 2'b00, 8'hc0);
    ot_evt <= 1'b1;
    @(posedge clock);
    ot_evt <= 1'b0;
    waitc(3);
    cmp_pin(3'b001, {2'b00, otf});
    dev(1'b1, ADDR_FUNC_CTRL, 8'hca, 2'b00, 8'h00);
    waitc(10);
    cmp_pin(3'b000, {2'b00, otf});
    err_pulse();
    enable_in <= 1'b0;
    waitc(3);
    cmp_pin(3'b000, {2'b00, fault});
    enable_in <= 1'b1;
    $display("test error clear done");
    uv <= 3'($urandom());
    hr <= 3'($urandom());
    // low time has to reach the measurement interval before the first pulse
    got = 3'b000;
    repeat (MEAS_CYC + RECHARGE_CYC + 100) begin
      @(negedge clock);
      got = got | rchg;
    end
    cmp_pin(3'b111, got);
    cmp_pin(~(uv | hr), maint);
    $display("test idle bootstrap done");
    wrap_up();
  end
endmodule : tb_led_channel_dimming_control
`default_nettype wire
